// file: design/rtcsp_device.sv
// How it works
// R01: Select low resets the serial logic
// R02: Eight-bit units, most significant bit first
// R03: Input sampled on rising serial clock
// R04: Output changes on falling edge, else released
// R05: Sampled bits move inward on falling edge
// R06: First byte command, rest are data
// R07: Command bit 7: zero write, one read
// R08: Subaddress must be 001, else ignore
// R09: Low four bits give start register
// R10: Address increments per byte, wraps to zero
// R11: Time counting frozen while access active
// R12: Stuck interface cleared after one second
// R13: Watchdog fires between one and two seconds
// R14: Each timeout loses one second of time
// R15: After timeout wait for select low
// R16: Host must lower select after transfer
// R17: Watchdog starts at valid subaddress, select clears
`timescale 1ns/1ns
`default_nettype none
module rtcsp_device
    import rtcsp_pkg::*;
#(
    parameter longint WDOG_CYCLES = RTCSP_WDOG_CYC
)
(
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    // Serial link
    rtcsp_if.device                         link,
    // Register side
    output logic [RTCSP_ADDR_BITS-1:0]      reg_addr,
    output logic [RTCSP_BYTE_BITS-1:0]      reg_wdata,
    output logic                            reg_write,
    output logic                            reg_read,
    input  wire logic [RTCSP_BYTE_BITS-1:0] reg_rdata,
    // Time keeping side
    output logic                            time_freeze,
    output logic                            time_lose_second
);
    localparam int BCW = $clog2(RTCSP_BYTE_BITS);
    localparam int WDW = $clog2(WDOG_CYCLES + 1);

    logic [1:0]                 sel_sync_reg;
    logic [2:0]                 clk_sync_reg;
    logic [1:0]                 din_sync_reg;
    logic                       sel;
    logic                       rise;
    logic                       fall;
    logic                       bit_in_reg;
    logic                       bit_pending_reg;
    logic [RTCSP_BYTE_BITS-1:0] shift_reg;
    logic [BCW-1:0]             count_reg;
    logic [RTCSP_BYTE_BITS-1:0] byte_next;
    logic                       byte_done;
    rtcsp_state_t               state_reg;
    logic                       dir_reg;
    logic [RTCSP_BYTE_BITS-1:0] tx_reg;
    logic                       drive_reg;
    logic [WDW-1:0]             wdog_reg;
    logic                       wdog_run_reg;
    logic                       wdog_fire;

    // Pins pass two flops; third stage only for edge detect
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_sync_reg <= 2'h0;
            clk_sync_reg <= 3'h0;
            din_sync_reg <= 2'h0;
        end
        else
        begin
            sel_sync_reg <= {sel_sync_reg[0], link.select};
            clk_sync_reg <= {clk_sync_reg[1:0], link.sclk};
            din_sync_reg <= {din_sync_reg[0], link.serial_in};
        end
    end

    assign sel  = sel_sync_reg[1];
    assign rise = sel && clk_sync_reg[1] && !clk_sync_reg[2];
    assign fall = sel && !clk_sync_reg[1] && clk_sync_reg[2];

    // Capture on rising edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_in_reg      <= 1'b0;
            bit_pending_reg <= 1'b0;
        end
        else if (!sel)
        begin
            bit_pending_reg <= 1'b0; // R01
        end
        else if (rise)
        begin
            bit_in_reg      <= din_sync_reg[1]; // R03
            bit_pending_reg <= 1'b1;
        end
        else if (fall)
        begin
            bit_pending_reg <= 1'b0;
        end
    end

    assign byte_next = {shift_reg[RTCSP_BYTE_BITS-2:0], bit_in_reg}; // R02
    assign byte_done = fall && bit_pending_reg && (count_reg == BCW'(RTCSP_BYTE_BITS - 1));

    // Shift in on falling edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_reg <= '0;
            count_reg <= '0;
        end
        else if (!sel)
        begin
            shift_reg <= '0; // R01
            count_reg <= '0;
        end
        else if (fall && bit_pending_reg)
        begin
            shift_reg <= byte_next; // R05
            count_reg <= count_reg + BCW'(1);
        end
    end

    // Command and data sequencing
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= RTCSP_ST_CMD;
            dir_reg   <= RTCSP_DIR_WRITE;
            reg_addr  <= '0;
        end
        else if (!sel)
        begin
            state_reg <= RTCSP_ST_CMD; // R01 R15
        end
        else if (wdog_fire)
        begin
            state_reg <= RTCSP_ST_LOCKED; // R12 R15
        end
        else if (byte_done)
        begin
            case (state_reg)
                RTCSP_ST_CMD:
                begin
                    dir_reg  <= byte_next[RTCSP_DIR_BIT]; // R07
                    reg_addr <= byte_next[RTCSP_ADDR_BITS-1:0]; // R09
                    if (byte_next[RTCSP_SUB_MSB:RTCSP_SUB_LSB] == RTCSP_SUB_CODE)
                        state_reg <= RTCSP_ST_DATA; // R06
                    else
                        state_reg <= RTCSP_ST_IGNORE; // R08
                end
                RTCSP_ST_DATA:
                    reg_addr <= reg_addr + RTCSP_ADDR_BITS'(dir_reg == RTCSP_DIR_READ); // R10
                RTCSP_ST_IGNORE:
                    state_reg <= RTCSP_ST_IGNORE;
                RTCSP_ST_LOCKED:
                    state_reg <= RTCSP_ST_LOCKED;
                default:
                    state_reg <= RTCSP_ST_CMD;
            endcase
        end
        else if (reg_write)
            reg_addr <= reg_addr + RTCSP_ADDR_BITS'(1); // R10
    end

    // Register strobes
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_wdata <= '0;
            reg_write <= 1'b0;
        end
        else
        begin
            reg_write <= byte_done && (state_reg == RTCSP_ST_DATA) && (dir_reg == RTCSP_DIR_WRITE) && !wdog_fire;
            if (byte_done)
                reg_wdata <= byte_next;
        end
    end

    assign reg_read = (state_reg == RTCSP_ST_DATA) && (dir_reg == RTCSP_DIR_READ) && (count_reg == '0)
                      && !drive_reg;

    // Read data out on falling edges
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_reg    <= '0;
            drive_reg <= 1'b0;
        end
        else if (!sel || state_reg != RTCSP_ST_DATA || dir_reg != RTCSP_DIR_READ || wdog_fire)
        begin
            drive_reg <= 1'b0; // R04 R08
        end
        else if (reg_read)
        begin
            tx_reg    <= reg_rdata;
            drive_reg <= 1'b1;
        end
        else if (byte_done)
        begin
            drive_reg <= 1'b0;
        end
        else if (fall && bit_pending_reg)
        begin
            tx_reg <= {tx_reg[RTCSP_BYTE_BITS-2:0], 1'b0}; // R04 R02
        end
    end

    assign link.serial_out    = tx_reg[RTCSP_BYTE_BITS-1];
    assign link.serial_out_oe = drive_reg; // R04

    // Watchdog counter
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wdog_reg     <= '0;
            wdog_run_reg <= 1'b0;
        end
        else if (!sel || wdog_fire)
        begin
            wdog_reg     <= '0; // R17
            wdog_run_reg <= 1'b0;
        end
        else if (byte_done && state_reg == RTCSP_ST_CMD
                 && byte_next[RTCSP_SUB_MSB:RTCSP_SUB_LSB] == RTCSP_SUB_CODE)
        begin
            wdog_run_reg <= 1'b1; // R17
        end
        else if (wdog_run_reg)
        begin
            wdog_reg <= wdog_reg + WDW'(1);
        end
    end

    assign wdog_fire = wdog_run_reg && (wdog_reg == WDW'(WDOG_CYCLES - 1)); // R12 R13

    // Freeze time while a valid access runs
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            time_freeze      <= 1'b0;
            time_lose_second <= 1'b0;
        end
        else
        begin
            time_freeze      <= sel && state_reg == RTCSP_ST_DATA && !wdog_fire; // R11
            time_lose_second <= wdog_fire; // R14
        end
    end
endmodule // rtcsp_device
`default_nettype wire

// file: design/rtcsp_pkg.sv
package rtcsp_pkg;
    localparam int          RTCSP_BYTE_BITS   = 8;
    localparam int          RTCSP_ADDR_BITS   = 4;
    localparam int          RTCSP_DIR_BIT     = 7;
    localparam int          RTCSP_SUB_MSB     = 6;
    localparam int          RTCSP_SUB_LSB     = 4;
    localparam logic [2:0]  RTCSP_SUB_CODE    = 3'h1;
    localparam logic        RTCSP_DIR_WRITE   = 1'b0;
    localparam logic        RTCSP_DIR_READ    = 1'b1;
    localparam longint      RTCSP_SYS_HZ      = 125000000;
    localparam int          RTCSP_WDOG_MIN_S  = 1;
    localparam int          RTCSP_WDOG_MAX_S  = 2;
    localparam longint      RTCSP_WDOG_CYC    = RTCSP_SYS_HZ * RTCSP_WDOG_MIN_S + 1;
    localparam int          RTCSP_HOST_DIV    = 8;

    typedef enum logic [1:0]
    {
        RTCSP_ST_CMD    = 2'b00,
        RTCSP_ST_DATA   = 2'b01,
        RTCSP_ST_IGNORE = 2'b11,
        RTCSP_ST_LOCKED = 2'b10
    } rtcsp_state_t;
endpackage

// file: design/rtcsp_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rtcsp_if;
    logic select;
    logic sclk;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe;
    modport device (input select, input sclk, input serial_in, output serial_out, output serial_out_oe);
    modport host   (output select, output sclk, output serial_in, input serial_out, input serial_out_oe);
endinterface
`default_nettype wire

// file: design/rtcsp_host.sv
`timescale 1ns/1ns
`default_nettype none
module rtcsp_host
    import rtcsp_pkg::*;
#(
    parameter int HALF_DIV = RTCSP_HOST_DIV
)
(
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    // Serial link
    rtcsp_if.host                           link,
    // User side
    input  wire logic                       start,
    input  wire logic                       stop,
    input  wire logic [RTCSP_BYTE_BITS-1:0] tx_byte,
    output logic                            tx_take,
    output logic [RTCSP_BYTE_BITS-1:0]      rx_byte,
    output logic                            rx_valid,
    output logic                            busy
);
    localparam int DW  = $clog2(HALF_DIV + 1);
    localparam int BCW = $clog2(RTCSP_BYTE_BITS + 1);

    logic [1:0]                 din_sync_reg;
    logic [DW-1:0]              div_reg;
    logic                       phase_tick;
    logic [RTCSP_BYTE_BITS-1:0] out_reg;
    logic [RTCSP_BYTE_BITS-1:0] in_reg;
    logic [BCW-1:0]             bit_reg;
    logic                       sclk_reg;
    logic                       sel_reg;
    logic                       stop_reg;

    assign phase_tick = div_reg == DW'(HALF_DIV - 1);
    assign tx_take    = busy && phase_tick && sclk_reg && bit_reg == BCW'(1) && !stop_reg;
    assign busy       = sel_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            din_sync_reg <= 2'h0;
        else
            din_sync_reg <= {din_sync_reg[0], link.serial_out_oe ? link.serial_out : 1'b0};
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            div_reg <= '0;
        else if (!sel_reg || phase_tick)
            div_reg <= '0;
        else
            div_reg <= div_reg + DW'(1);
    end

    // Byte engine, first byte is the command, select low ends it
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_reg  <= 1'b0;
            sclk_reg <= 1'b0;
            out_reg  <= '0;
            in_reg   <= '0;
            bit_reg  <= '0;
            stop_reg <= 1'b0;
            rx_byte  <= '0;
            rx_valid <= 1'b0;
        end
        else
        begin
            rx_valid <= 1'b0;
            if (!sel_reg)
            begin
                if (start)
                begin
                    sel_reg  <= 1'b1;
                    out_reg  <= tx_byte;
                    bit_reg  <= BCW'(RTCSP_BYTE_BITS);
                    stop_reg <= 1'b0;
                end
            end
            else
            begin
                if (stop)
                    stop_reg <= 1'b1;
                if (phase_tick)
                begin
                    if (bit_reg == '0)
                    begin
                        sel_reg <= 1'b0; // R16 R15
                    end
                    else if (!sclk_reg)
                    begin
                        sclk_reg <= 1'b1; // R03
                        in_reg   <= {in_reg[RTCSP_BYTE_BITS-2:0], din_sync_reg[1]};
                    end
                    else
                    begin
                        sclk_reg <= 1'b0;
                        if (bit_reg == BCW'(1))
                        begin
                            rx_byte  <= in_reg; // R02
                            rx_valid <= 1'b1;
                            // Clock parks low a half period before select drops
                            if (stop_reg || stop)
                                bit_reg <= '0; // R16
                            else
                            begin
                                out_reg <= tx_byte; // R06
                                bit_reg <= BCW'(RTCSP_BYTE_BITS);
                            end
                        end
                        else
                        begin
                            out_reg <= {out_reg[RTCSP_BYTE_BITS-2:0], 1'b0}; // R02
                            bit_reg <= bit_reg - BCW'(1);
                        end
                    end
                end
            end
        end
    end

    assign link.select    = sel_reg;
    assign link.sclk      = sclk_reg;
    assign link.serial_in = out_reg[RTCSP_BYTE_BITS-1];
endmodule // rtcsp_host
`default_nettype wire

// file: testbench/rtcsp_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rtcsp_properties
#(
    parameter longint WDOG_CYCLES = 2000
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link
    input wire logic select,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    // Device side
    input wire logic reg_write,
    input wire logic time_freeze,
    input wire logic time_lose_second
);
    logic   locked_reg;
    longint frz_cnt_reg;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            locked_reg <= 1'b0;
        else if (time_lose_second)
            locked_reg <= 1'b1;
        else if (!select)
            locked_reg <= 1'b0;
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            frz_cnt_reg <= 0;
        else
            frz_cnt_reg <= time_freeze ? frz_cnt_reg + 1 : 0;
    end
    oe_idle_a: assert property (!select [*4] |-> !serial_out_oe)
        else $error("output driven while deselected");
    freeze_idle_a: assert property (!select [*4] |-> !time_freeze)
        else $error("freeze while deselected");
    sdo_edge_a: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> !sclk)
        else $error("output changed with clock high");
    sdi_edge_a: assert property (select && $past(select) && $changed(serial_in) |-> !sclk)
        else $error("input changed with clock high");
    oe_valid_a: assert property (serial_out_oe |-> time_freeze)
        else $error("output driven outside valid access");
    write_freeze_a: assert property (reg_write |-> time_freeze && select)
        else $error("write outside data phase");
    lose_resume_a: assert property (time_lose_second |-> frz_cnt_reg >= WDOG_CYCLES - 4 ##1 !time_freeze)
        else $error("timeout early or freeze kept");
    wdog_bound_a: assert property (frz_cnt_reg <= WDOG_CYCLES + 4)
        else $error("freeze outlived watchdog");
    lock_quiet_a: assert property (locked_reg |-> !reg_write)
        else $error("write after timeout");
    write_c: cover property (reg_write);
    read_c: cover property ($rose(serial_out_oe));
    lose_c: cover property (time_lose_second);
endmodule // rtcsp_properties
`default_nettype wire

// file: testbench/rtc_three_line_serial_port_test.sv
`timescale 1ns/1ns
`default_nettype none
module rtc_three_line_serial_port_test;
    import rtcsp_pkg::*;
    localparam longint WDOG = 2000;
    logic       sys_clk = 0, rst_n = 0, start = 0, stop = 0, locked = 0;
    logic [7:0] tx_byte = 8'h00, rx_byte, reg_wdata, reg_rdata;
    logic [3:0] reg_addr;
    logic       reg_write, reg_read, time_freeze, time_lose_second, tx_take, rx_valid, busy;
    logic [7:0] mem [16];
    logic [7:0] rxq [$];
    logic [7:0] q [$];
    int         n_errors = 0, tests_run = 0, n_wr = 0, n_lose = 0, n_lockwr = 0, n_oe = 0, n_frz = 0;
    int         w, f, o;
    rtcsp_if link ();
    always #4 sys_clk = ~sys_clk;
    assign reg_rdata = mem[reg_addr];
    rtcsp_host rtcsp_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link), .start(start), .stop(stop),
        .tx_byte(tx_byte), .tx_take(tx_take), .rx_byte(rx_byte), .rx_valid(rx_valid), .busy(busy));
    rtcsp_device #(.WDOG_CYCLES(WDOG)) rtcsp_device_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .time_freeze(time_freeze), .time_lose_second(time_lose_second));
    rtcsp_properties #(.WDOG_CYCLES(WDOG)) rtcsp_properties_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .select(link.select), .sclk(link.sclk), .serial_in(link.serial_in), .serial_out(link.serial_out),
        .serial_out_oe(link.serial_out_oe), .reg_write(reg_write), .time_freeze(time_freeze),
        .time_lose_second(time_lose_second));
    // Register file and event counters
    always @(posedge sys_clk)
    begin
        if (reg_write === 1'b1)
        begin
            mem[reg_addr] <= reg_wdata;
            n_wr++;
            if (locked)
                n_lockwr++;
        end
        if (rx_valid === 1'b1)
            rxq.push_back(rx_byte);
        if (link.serial_out_oe === 1'b1)
            n_oe++;
        if (time_freeze === 1'b1)
            n_frz++;
        if (time_lose_second === 1'b1)
        begin
            n_lose++;
            locked = 1;
        end
        else if (link.select === 1'b0)
            locked = 0;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Command then data; hold keeps stop low at the last take, but stop still rises before the next clock
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] data [$], input bit hold);
        int i;
        int t;
        rxq.delete();
        @(posedge sys_clk) #1;
        tx_byte = cmd;
        start = 1;
        @(posedge sys_clk) #1;
        start = 0;
        tx_byte = data[0];
        i = 0;
        for (t = 0; i < data.size() && t < 6000; t++)
        begin
            @(posedge sys_clk);
            if (tx_take === 1'b1)
            begin
                i++;
                #1;
                if (i < data.size())
                    tx_byte = data[i];
                stop = (i == data.size()) && !hold;
            end
        end
        check(8'(i == data.size()), 8'h01);
        #1 stop = 1;
        for (t = 0; t < 3000 && busy !== 1'b0; t++)
            @(posedge sys_clk);
        #1 stop = 0;
        check(8'(busy), 8'h00);
        repeat (20) @(posedge sys_clk);
    endtask
    initial
    begin
        foreach (mem[k])
            mem[k] = 8'h00;
        repeat (6) @(posedge sys_clk);
        #1 rst_n = 1;
        xfer(8'h1e, '{8'ha5, 8'h3c, 8'h81}, 0);
        check(mem[4'he], 8'ha5);
        check(mem[4'hf], 8'h3c);
        check(mem[4'h0], 8'h81);
        check(8'(n_frz != 0), 8'h01);
        xfer(8'h9e, '{8'h00, 8'h00, 8'h00}, 0);
        check(rxq[rxq.size() - 3], 8'ha5);
        check(rxq[rxq.size() - 2], 8'h3c);
        check(rxq[rxq.size() - 1], 8'h81);
        for (int s = 0; s < 8; s++)
            if (s != 1)
            begin
                w = n_wr;
                f = n_frz;
                o = n_oe;
                xfer({s[0], s[2:0], 4'h2}, '{8'h5a}, 0);
                check(8'(n_wr - w), 8'h00);
                check(8'(n_frz - f), 8'h00);
                check(8'(n_oe - o), 8'h00);
            end
        check(mem[4'h2], 8'h00);
        q = {};
        repeat (24)
            q.push_back(8'h66);
        w = n_wr;
        xfer(8'h12, q, 1);
        check(8'(n_lose), 8'h01);
        check(8'(n_lockwr), 8'h00);
        check(8'(n_wr - w >= WDOG / 136 && n_wr - w < 24), 8'h01);
        check(8'(time_freeze), 8'h00);
        xfer(8'h9e, '{8'h00}, 0);
        check(rxq[rxq.size() - 1], 8'h66);
        stop_test();
    end
    initial
    begin
        #300000;
        n_errors++;
        stop_test();
    end
endmodule // rtc_three_line_serial_port_test
`default_nettype wire
